// file: hw/mcelb_pkg.sv
// Purpose: Shared constants, field positions and carrier types for the memory error log banks.
// Assumes: One clock, synchronous active-low reset, registers reached through the MSR port.
// Notes: Banks 8 to 11 map to local bank indices 0 to 3.
package mcelb_pkg;

  // Bank count and the architectural number of the first bank.
  localparam int unsigned MCELB_BANKS = 4;
  localparam int unsigned MCELB_FIRST_BANK = 8;

  // MSR indices: status of bank b at 2*b, misc at 2*b+1, control after the banks.
  localparam logic [3:0] MCELB_IDX_BANK_LIMIT = 4'h8;
  localparam logic [3:0] MCELB_IDX_CTRL = 4'h8;

  // Extended-logging control bit position.
  localparam int unsigned MCELB_CTRL_EXT_BIT = 1;

  // Status register field positions.
  localparam int unsigned MCELB_ST_CLASS_LSB = 0;
  localparam int unsigned MCELB_ST_CLASS_MSB = 15;
  localparam int unsigned MCELB_ST_MS_LSB = 16;
  localparam int unsigned MCELB_ST_MS_MSB = 31;
  localparam int unsigned MCELB_ST_FDEV_LSB = 32;
  localparam int unsigned MCELB_ST_FDEV_MSB = 36;
  localparam int unsigned MCELB_ST_RSVD_BIT = 37;

  // Miscellaneous register field positions.
  localparam int unsigned MCELB_MI_SDEV_LSB = 9;
  localparam int unsigned MCELB_MI_SDEV_MSB = 13;
  localparam int unsigned MCELB_MI_FMASK_LSB = 14;
  localparam int unsigned MCELB_MI_FMASK_MSB = 29;
  localparam int unsigned MCELB_MI_SMASK_LSB = 30;
  localparam int unsigned MCELB_MI_SMASK_MSB = 45;
  localparam int unsigned MCELB_MI_FRANK_LSB = 46;
  localparam int unsigned MCELB_MI_FRANK_MSB = 50;
  localparam int unsigned MCELB_MI_SRANK_LSB = 51;
  localparam int unsigned MCELB_MI_SRANK_MSB = 55;
  localparam int unsigned MCELB_MI_FSLOT_LSB = 56;
  localparam int unsigned MCELB_MI_FSLOT_MSB = 58;
  localparam int unsigned MCELB_MI_SSLOT_LSB = 59;
  localparam int unsigned MCELB_MI_SSLOT_MSB = 61;
  localparam int unsigned MCELB_MI_FVALID_BIT = 62;
  localparam int unsigned MCELB_MI_SVALID_BIT = 63;

  // Model-specific codes placed in status bits 31:16.
  localparam logic [15:0] MCELB_MS_NONE = 16'h0000;
  localparam logic [15:0] MCELB_MS_ADDR_PAR = 16'h0001;
  localparam logic [15:0] MCELB_MS_WB_DATA_PAR = 16'h0002;
  localparam logic [15:0] MCELB_MS_WR_BE_PAR = 16'h0004;
  localparam logic [15:0] MCELB_MS_SCRUB_CORR = 16'h0008;
  localparam logic [15:0] MCELB_MS_SCRUB_UNC = 16'h0010;
  localparam logic [15:0] MCELB_MS_SPARE_CORR = 16'h0020;
  localparam logic [15:0] MCELB_MS_SPARE_UNC = 16'h0040;

  // Upper byte of the compound memory error class code is always zero.
  localparam logic [7:0] MCELB_CLASS_HIGH = 8'h00;

  // Kind of error reported by the memory controller.
  typedef enum logic [2:0] {
    MCELB_K_READ_CORR = 3'h0,
    MCELB_K_ADDR_PAR = 3'h1,
    MCELB_K_WB_DATA_PAR = 3'h2,
    MCELB_K_WR_BE_PAR = 3'h3,
    MCELB_K_SCRUB_CORR = 3'h4,
    MCELB_K_SCRUB_UNC = 3'h5,
    MCELB_K_SPARE_CORR = 3'h6,
    MCELB_K_SPARE_UNC = 3'h7
  } mcelb_kind_e;

  // One error report from the memory controller.
  typedef struct packed {
    logic valid;
    logic [1:0] bank;
    logic [2:0] mmm;
    logic [3:0] cccc;
    mcelb_kind_e kind;
    logic [4:0] dev_id;
    logic [15:0] mask;
    logic [4:0] rank;
    logic [2:0] slot;
    logic [4:0] parity;
  } mcelb_event_s;

  // One MSR access request.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] index;
    logic [63:0] wdata;
  } mcelb_msr_req_s;

  // Whole state of the top module.
  typedef struct packed {
    logic [MCELB_BANKS-1:0][63:0] status;
    logic [MCELB_BANKS-1:0][63:0] misc;
    logic ext_en;
    logic [63:0] rdata;
    logic rvalid;
    logic fault;
  } mcelb_state_s;

  localparam mcelb_state_s MCELB_STATE_RST = '0;

endpackage

// file: hw/mcelb_bank_upd.sv
// Purpose: Next-value logic of one error log bank when an error report hits it.
// Assumes: Inputs already carry any software write of this cycle.
// Notes: Purely combinational; the top registers the result.
module mcelb_bank_upd
  import mcelb_pkg::*;
(
  input wire logic ext_en,
  input wire logic hit,
  input wire mcelb_event_s ev,
  input wire logic [63:0] status_in,
  input wire logic [63:0] misc_in,
  output logic [63:0] status_out,
  output logic [63:0] misc_out
);

  // Maps an error kind to its model-specific code; a corrected read carries none.
  function automatic logic [15:0] ms_code(input mcelb_kind_e kind);
    logic [15:0] code;
    code = MCELB_MS_NONE;
    unique case (kind)
      MCELB_K_READ_CORR: code = MCELB_MS_NONE;
      MCELB_K_ADDR_PAR: code = MCELB_MS_ADDR_PAR;
      MCELB_K_WB_DATA_PAR: code = MCELB_MS_WB_DATA_PAR;
      MCELB_K_WR_BE_PAR: code = MCELB_MS_WR_BE_PAR;
      MCELB_K_SCRUB_CORR: code = MCELB_MS_SCRUB_CORR;
      MCELB_K_SCRUB_UNC: code = MCELB_MS_SCRUB_UNC;
      MCELB_K_SPARE_CORR: code = MCELB_MS_SPARE_CORR;
      MCELB_K_SPARE_UNC: code = MCELB_MS_SPARE_UNC;
    endcase
    return code;
  endfunction

  logic corr_read;
  logic parity_kind;

  assign corr_read = ext_en && (ev.kind == MCELB_K_READ_CORR);
  assign parity_kind = (ev.kind == MCELB_K_WB_DATA_PAR) || (ev.kind == MCELB_K_WR_BE_PAR);

  // The event is applied on top of the software write so that capture wins a collision.
  always_comb begin
    status_out = status_in;
    misc_out = misc_in;
    if (hit) begin
      status_out[MCELB_ST_CLASS_MSB:MCELB_ST_CLASS_LSB] =
        {MCELB_CLASS_HIGH, 1'b1, ev.mmm, ev.cccc};
      status_out[MCELB_ST_MS_MSB:MCELB_ST_MS_LSB] = ms_code(ev.kind);
      if (corr_read) begin
        // The first device slot fills first; later errors go to the second slot once.
        if (!misc_in[MCELB_MI_FVALID_BIT]) begin
          status_out[MCELB_ST_FDEV_MSB:MCELB_ST_FDEV_LSB] = ev.dev_id;
          misc_out[MCELB_MI_FMASK_MSB:MCELB_MI_FMASK_LSB] = ev.mask;
          misc_out[MCELB_MI_FRANK_MSB:MCELB_MI_FRANK_LSB] = ev.rank;
          misc_out[MCELB_MI_FSLOT_MSB:MCELB_MI_FSLOT_LSB] = ev.slot;
          misc_out[MCELB_MI_FVALID_BIT] = 1'b1;
        end else if (!misc_in[MCELB_MI_SVALID_BIT]) begin
          misc_out[MCELB_MI_SDEV_MSB:MCELB_MI_SDEV_LSB] = ev.dev_id;
          misc_out[MCELB_MI_SMASK_MSB:MCELB_MI_SMASK_LSB] = ev.mask;
          misc_out[MCELB_MI_SRANK_MSB:MCELB_MI_SRANK_LSB] = ev.rank;
          misc_out[MCELB_MI_SSLOT_MSB:MCELB_MI_SSLOT_LSB] = ev.slot;
          misc_out[MCELB_MI_SVALID_BIT] = 1'b1;
        end
      end else if (!ext_en && parity_kind) begin
        misc_out[MCELB_MI_SDEV_MSB:MCELB_MI_SDEV_LSB] = ev.parity;
      end
    end
    // Bit 37 never holds information, whatever software writes.
    status_out[MCELB_ST_RSVD_BIT] = 1'b0;
  end

endmodule

// file: hw/mcelb_top.sv
// Purpose: Error log banks 8 to 11 of the integrated memory controller, read and written as MSRs.
// Assumes: Error reports and MSR requests come from logic on CLOCK; no synchronisers needed.
// Notes: Architectural status and misc fields are plain software storage here.

// Contract
// - Memory controller errors are logged in banks 8 to 11, status plus misc each.
// - Status bits 15:0 hold the compound memory class code 1MMMCCCC.
// - Control bit 1 enables extra detail in both status and misc registers.
// - Status bits 31:16 hold the model-specific code of the error kind.
// - Extended logging stores the first failing device in status bits 36:32.
// - Extended logging stores the second failing device in misc bits 13:9.
// - Without extended logging, misc 13:9 hold parity detail for write parity errors.
// - Extended logging stores the first device bit mask in misc 29:14.
// - Extended logging stores the second device bit mask in misc 45:30.
// - Extended logging stores the first device failing rank in misc 50:46.
// - Extended logging stores the second device failing rank in misc 55:51.
// - Extended logging stores the first device failing slot in misc 58:56.
// - Extended logging stores the second device failing slot in misc 61:59.
// - Misc bit 62 is set once first device information is captured.
// - Misc bit 63 is set once second device information is captured.
module mcelb_top
  import mcelb_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire mcelb_event_s ERR_EVENT,
  input wire mcelb_msr_req_s MSR_REQ,
  output logic [63:0] MSR_RDATA,
  output logic MSR_RVALID,
  output logic MSR_FAULT,
  output logic EXT_LOG_EN
);

  mcelb_state_s st_r;
  mcelb_state_s st_nxt;

  logic in_bank_range;
  logic is_ctrl;
  logic mapped;
  logic [1:0] req_bank;
  logic req_is_misc;
  logic [1:0] eb;
  logic [63:0] read_word;

  logic [MCELB_BANKS-1:0] wr_status_hit;
  logic [MCELB_BANKS-1:0] wr_misc_hit;
  logic [MCELB_BANKS-1:0] ev_hit;
  logic [MCELB_BANKS-1:0] rsvd_bits;
  logic [MCELB_BANKS-1:0][63:0] post_status;
  logic [MCELB_BANKS-1:0][63:0] post_misc;
  logic [MCELB_BANKS-1:0][63:0] upd_status;
  logic [MCELB_BANKS-1:0][63:0] upd_misc;

  // Address decode: indices below the limit pick a bank, its low bit picks misc over status.
  assign in_bank_range = MSR_REQ.index < MCELB_IDX_BANK_LIMIT;
  assign is_ctrl = MSR_REQ.index == MCELB_IDX_CTRL;
  assign mapped = in_bank_range || is_ctrl;
  assign req_bank = MSR_REQ.index[2:1];
  assign req_is_misc = MSR_REQ.index[0];
  assign eb = ERR_EVENT.bank;

  // One update slice per bank; the error report carries the bank it belongs to.
  for (genvar b = 0; b < MCELB_BANKS; b++) begin : g_bank
    assign wr_status_hit[b] = MSR_REQ.wr && in_bank_range && (req_bank == 2'(b)) && !req_is_misc;
    assign wr_misc_hit[b] = MSR_REQ.wr && in_bank_range && (req_bank == 2'(b)) && req_is_misc;
    assign ev_hit[b] = ERR_EVENT.valid && (eb == 2'(b));
    assign post_status[b] = wr_status_hit[b] ? MSR_REQ.wdata : st_r.status[b];
    assign post_misc[b] = wr_misc_hit[b] ? MSR_REQ.wdata : st_r.misc[b];
    assign rsvd_bits[b] = st_r.status[b][MCELB_ST_RSVD_BIT];

    mcelb_bank_upd u_upd (
      .ext_en(st_r.ext_en),
      .hit(ev_hit[b]),
      .ev(ERR_EVENT),
      .status_in(post_status[b]),
      .misc_in(post_misc[b]),
      .status_out(upd_status[b]),
      .misc_out(upd_misc[b])
    );
  end

  // Read multiplexer; unmapped indices read as zero and raise a fault.
  always_comb begin
    read_word = 64'h0000000000000000;
    if (in_bank_range) begin
      read_word = req_is_misc ? st_r.misc[req_bank] : st_r.status[req_bank];
    end else if (is_ctrl) begin
      read_word[MCELB_CTRL_EXT_BIT] = st_r.ext_en;
    end
  end

  // Next state: bank contents, control bit and the registered read answer.
  always_comb begin
    st_nxt = st_r;
    st_nxt.status = upd_status;
    st_nxt.misc = upd_misc;
    if (MSR_REQ.wr && is_ctrl) begin
      st_nxt.ext_en = MSR_REQ.wdata[MCELB_CTRL_EXT_BIT];
    end
    st_nxt.rvalid = MSR_REQ.rd;
    st_nxt.fault = (MSR_REQ.rd || MSR_REQ.wr) && !mapped;
    if (MSR_REQ.rd) begin
      st_nxt.rdata = read_word;
    end
  end

  // The whole block state lives in one register.
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      st_r <= MCELB_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign MSR_RDATA = st_r.rdata;
  assign MSR_RVALID = st_r.rvalid;
  assign MSR_FAULT = st_r.fault;
  assign EXT_LOG_EN = st_r.ext_en;

  // Helper terms for the checks below; they name the capture cases without a same-bank write to the words each check reads.
  logic first_cap;
  logic second_cap;
  logic parity_cap;
  logic ext_off_ev;

  assign first_cap = ERR_EVENT.valid && st_r.ext_en && (ERR_EVENT.kind == MCELB_K_READ_CORR) &&
    !st_r.misc[eb][MCELB_MI_FVALID_BIT] && !wr_misc_hit[eb] && !wr_status_hit[eb];
  assign second_cap = ERR_EVENT.valid && st_r.ext_en && (ERR_EVENT.kind == MCELB_K_READ_CORR) &&
    st_r.misc[eb][MCELB_MI_FVALID_BIT] && !st_r.misc[eb][MCELB_MI_SVALID_BIT] &&
    !wr_misc_hit[eb];
  assign parity_cap = ERR_EVENT.valid && !st_r.ext_en && !wr_misc_hit[eb] &&
    ((ERR_EVENT.kind == MCELB_K_WB_DATA_PAR) || (ERR_EVENT.kind == MCELB_K_WR_BE_PAR));
  assign ext_off_ev = ERR_EVENT.valid && !st_r.ext_en && !wr_misc_hit[eb];

  // Shorthands for the checks: the hit bank's words, each bank's code field, report kinds.
  logic [63:0] ev_st;
  logic [63:0] ev_mi;
  logic ev_corr;
  logic ev_par;
  logic [MCELB_BANKS-1:0][15:0] ms_field;

  assign ev_st = st_r.status[eb];
  assign ev_mi = st_r.misc[eb];
  assign ev_corr = ERR_EVENT.valid && (ERR_EVENT.kind == MCELB_K_READ_CORR);
  assign ev_par = ERR_EVENT.valid &&
    ((ERR_EVENT.kind == MCELB_K_WB_DATA_PAR) || (ERR_EVENT.kind == MCELB_K_WR_BE_PAR));
  for (genvar b = 0; b < MCELB_BANKS; b++) begin : g_ms
    assign ms_field[b] = st_r.status[b][MCELB_ST_MS_MSB:MCELB_ST_MS_LSB];
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  // The class code is always of the compound memory form with the reported fields.
  a_class_code_form:
    assert property (ERR_EVENT.valid |=>
      st_r.status[$past(eb)][MCELB_ST_CLASS_MSB:MCELB_ST_CLASS_LSB] ==
      {MCELB_CLASS_HIGH, 1'b1, $past(ERR_EVENT.mmm), $past(ERR_EVENT.cccc)})
    else $error("class code not in compound memory form");

  // Address parity errors carry their model-specific code.
  a_ms_addr_code:
    assert property (ERR_EVENT.valid && (ERR_EVENT.kind == MCELB_K_ADDR_PAR) |=>
      st_r.status[$past(eb)][MCELB_ST_MS_MSB:MCELB_ST_MS_LSB] == MCELB_MS_ADDR_PAR)
    else $error("address parity code wrong");

  // Uncorrected spare errors carry their model-specific code.
  a_ms_spare_code:
    assert property (ERR_EVENT.valid && (ERR_EVENT.kind == MCELB_K_SPARE_UNC) |=>
      st_r.status[$past(eb)][MCELB_ST_MS_MSB:MCELB_ST_MS_LSB] == MCELB_MS_SPARE_UNC)
    else $error("uncorrected spare code wrong");

  // A report for another bank leaves bank 8 untouched.
  a_bank_isolation:
    assert property (ERR_EVENT.valid && (eb != 2'h0) && !MSR_REQ.wr |=>
      $stable(st_r.status[0]) && $stable(st_r.misc[0]))
    else $error("report for another bank changed bank 8");

  // Reserved status bit 37 never reads one in any bank.
  a_reserved_bit:
    assert property (rsvd_bits == 4'h0)
    else $error("status bit 37 set");

  // First device capture fills status 36:32 and the first misc fields and sets bit 62, all one cycle after the report.
  a_first_capture:
    assert property (first_cap |=>
      st_r.misc[$past(eb)][MCELB_MI_FVALID_BIT] &&
      (st_r.status[$past(eb)][MCELB_ST_FDEV_MSB:MCELB_ST_FDEV_LSB] == $past(ERR_EVENT.dev_id)) &&
      (st_r.misc[$past(eb)][MCELB_MI_FMASK_MSB:MCELB_MI_FMASK_LSB] == $past(ERR_EVENT.mask)) &&
      (st_r.misc[$past(eb)][MCELB_MI_FRANK_MSB:MCELB_MI_FRANK_LSB] == $past(ERR_EVENT.rank)) &&
      (st_r.misc[$past(eb)][MCELB_MI_FSLOT_MSB:MCELB_MI_FSLOT_LSB] == $past(ERR_EVENT.slot)) &&
      (st_r.misc[$past(eb)][MCELB_MI_SVALID_BIT] ==
      $past(st_r.misc[eb][MCELB_MI_SVALID_BIT])))
    else $error("first device capture wrong");

  // Second device capture fills the second misc fields and sets bit 63, keeping bit 62.
  a_second_capture:
    assert property (second_cap |=>
      st_r.misc[$past(eb)][MCELB_MI_SVALID_BIT] &&
      st_r.misc[$past(eb)][MCELB_MI_FVALID_BIT] &&
      (st_r.misc[$past(eb)][MCELB_MI_SDEV_MSB:MCELB_MI_SDEV_LSB] == $past(ERR_EVENT.dev_id)) &&
      (st_r.misc[$past(eb)][MCELB_MI_SMASK_MSB:MCELB_MI_SMASK_LSB] == $past(ERR_EVENT.mask)) &&
      (st_r.misc[$past(eb)][MCELB_MI_SRANK_MSB:MCELB_MI_SRANK_LSB] == $past(ERR_EVENT.rank)) &&
      (st_r.misc[$past(eb)][MCELB_MI_SSLOT_MSB:MCELB_MI_SSLOT_LSB] == $past(ERR_EVENT.slot)))
    else $error("second device capture wrong");

  // Write parity errors without extended logging put the parity detail in misc 13:9.
  a_parity_detail:
    assert property (parity_cap |=>
      st_r.misc[$past(eb)][MCELB_MI_SDEV_MSB:MCELB_MI_SDEV_LSB] == $past(ERR_EVENT.parity))
    else $error("parity detail not logged");

  // With extended logging off the device fields above bit 13 do not move.
  a_ext_off_hold:
    assert property (ext_off_ev |=>
      st_r.misc[$past(eb)][63:14] == $past(st_r.misc[eb][63:14]))
    else $error("device fields changed with extended logging off");

  // A control write reaches the enable, which shows on EXT_LOG_EN a cycle later.
  a_ext_control:
    assert property (MSR_REQ.wr && is_ctrl |=>
      (EXT_LOG_EN == $past(MSR_REQ.wdata[MCELB_CTRL_EXT_BIT])))
    else $error("extended logging enable not written");

  // Every read is answered exactly one cycle later, and faults only for unmapped indices.
  a_read_answer:
    assert property (MSR_REQ.rd |=> MSR_RVALID && (MSR_FAULT == !$past(mapped)))
    else $error("read answer missing or fault wrong");

  // A status read returns the word held before the read edge.
  a_status_read:
    assert property (MSR_REQ.rd && in_bank_range && !req_is_misc |=>
      MSR_RDATA == $past(st_r.status[req_bank]))
    else $error("status read data wrong");

  // A misc read returns the word held before the read edge.
  a_misc_read:
    assert property (MSR_REQ.rd && in_bank_range && req_is_misc |=>
      MSR_RDATA == $past(st_r.misc[req_bank]))
    else $error("misc read data wrong");

  // A control read shows only the enable, in bit 1.
  a_ctrl_read:
    assert property (MSR_REQ.rd && is_ctrl |=>
      MSR_RDATA == {62'h0, $past(st_r.ext_en), 1'b0})
    else $error("control read data wrong");

  // An unmapped read returns zero and faults.
  a_unmapped_read:
    assert property (MSR_REQ.rd && !mapped |=>
      MSR_FAULT && (MSR_RDATA == 64'h0000000000000000))
    else $error("unmapped read not refused");

  // The read answer is a pulse and never comes without a request.
  a_rvalid_pulse:
    assert property (!MSR_REQ.rd |=>
      !MSR_RVALID)
    else $error("read answer without request");

  // A status write without a report lands whole except the reserved bit.
  a_status_write:
    assert property (MSR_REQ.wr && in_bank_range && !req_is_misc && !ev_hit[req_bank] |=>
      (st_r.status[$past(req_bank)][63:38] == $past(MSR_REQ.wdata[63:38])) &&
      (st_r.status[$past(req_bank)][36:0] == $past(MSR_REQ.wdata[36:0])))
    else $error("status write lost");

  // A misc write without a report lands whole.
  a_misc_write:
    assert property (MSR_REQ.wr && in_bank_range && req_is_misc && !ev_hit[req_bank] |=>
      st_r.misc[$past(req_bank)] == $past(MSR_REQ.wdata))
    else $error("misc write lost");

  // A write to an unmapped index changes nothing.
  a_unmapped_write:
    assert property (MSR_REQ.wr && !mapped && !ERR_EVENT.valid |=>
      $stable(st_r.status) && $stable(st_r.misc) && $stable(EXT_LOG_EN))
    else $error("unmapped write changed state");

  // Only a control write moves the enable.
  a_ext_hold:
    assert property (!(MSR_REQ.wr && is_ctrl) |=>
      $stable(EXT_LOG_EN))
    else $error("extended logging enable moved");

  // Corrected reads carry no model-specific code.
  a_ms_read_code:
    assert property (ev_corr |=>
      ms_field[$past(eb)] == MCELB_MS_NONE)
    else $error("corrected read code wrong");

  // Write buffer data parity errors carry their code.
  a_ms_wb_code:
    assert property (ERR_EVENT.valid && (ERR_EVENT.kind == MCELB_K_WB_DATA_PAR) |=>
      ms_field[$past(eb)] == MCELB_MS_WB_DATA_PAR)
    else $error("write buffer parity code wrong");

  // Write byte enable parity errors carry their code.
  a_ms_be_code:
    assert property (ERR_EVENT.valid && (ERR_EVENT.kind == MCELB_K_WR_BE_PAR) |=>
      ms_field[$past(eb)] == MCELB_MS_WR_BE_PAR)
    else $error("byte enable parity code wrong");

  // Corrected patrol scrub errors carry their code.
  a_scrub_corr_code:
    assert property (ERR_EVENT.valid && (ERR_EVENT.kind == MCELB_K_SCRUB_CORR) |=>
      ms_field[$past(eb)] == MCELB_MS_SCRUB_CORR)
    else $error("corrected scrub code wrong");

  // Uncorrected patrol scrub errors carry their code.
  a_scrub_unc_code:
    assert property (ERR_EVENT.valid && (ERR_EVENT.kind == MCELB_K_SCRUB_UNC) |=>
      ms_field[$past(eb)] == MCELB_MS_SCRUB_UNC)
    else $error("uncorrected scrub code wrong");

  // Corrected spare errors carry their code.
  a_spare_corr_code:
    assert property (ERR_EVENT.valid && (ERR_EVENT.kind == MCELB_K_SPARE_CORR) |=>
      ms_field[$past(eb)] == MCELB_MS_SPARE_CORR)
    else $error("corrected spare code wrong");

  // Full device records ignore further corrected reads.
  a_third_report:
    assert property (ev_corr && st_r.ext_en && ev_mi[MCELB_MI_FVALID_BIT] &&
      ev_mi[MCELB_MI_SVALID_BIT] && !wr_misc_hit[eb] |=> st_r.misc[$past(eb)] == $past(ev_mi))
    else $error("full device records changed");

  // The first device number moves only on a first capture.
  a_fdev_kept:
    assert property (ERR_EVENT.valid && (!st_r.ext_en || ev_mi[MCELB_MI_FVALID_BIT]) &&
      !wr_misc_hit[eb] && !wr_status_hit[eb] |=>
      st_r.status[$past(eb)][MCELB_ST_FDEV_MSB:MCELB_ST_FDEV_LSB] ==
      $past(ev_st[MCELB_ST_FDEV_MSB:MCELB_ST_FDEV_LSB]))
    else $error("first device number moved");

  // With extended logging on, write parity reports leave misc alone.
  a_parity_ext_on:
    assert property (ev_par && st_r.ext_en && !wr_misc_hit[eb] |=>
      st_r.misc[$past(eb)] == $past(ev_mi))
    else $error("parity detail logged with extended logging on");

  // Main scenarios worth seeing in a run.
  c_first_capture:
    cover property (first_cap ##1 second_cap);
  c_parity_detail:
    cover property (parity_cap);
  c_unmapped_read:
    cover property (MSR_REQ.rd && !mapped);
  c_ctrl_enable:
    cover property (MSR_REQ.wr && is_ctrl && MSR_REQ.wdata[MCELB_CTRL_EXT_BIT]);
  c_third_report:
    cover property (ev_corr && st_r.ext_en && ev_mi[MCELB_MI_SVALID_BIT]);

endmodule

// file: tb/mcelb_tb.sv
// Purpose: Self-checking bench for the memory error log banks, driven through the MSR port.
// Assumes: Reads answer one cycle after the request; reports land at the edge that takes them.
// Notes: Every scenario is its own task; expected values come from the field layout alone.
module mcelb_tb
  import mcelb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic reset_n;
  mcelb_event_s ev;
  mcelb_msr_req_s req;
  logic [63:0] rdata;
  logic rvalid;
  logic fault;
  logic ext_en;
  int n_fail;
  int checks_done;
  int cycles;
  logic [63:0] d;
  logic f;

  mcelb_top dut (
    .CLOCK(clock),
    .RESET_N(reset_n),
    .ERR_EVENT(ev),
    .MSR_REQ(req),
    .MSR_RDATA(rdata),
    .MSR_RVALID(rvalid),
    .MSR_FAULT(fault),
    .EXT_LOG_EN(ext_en)
  );

  // A 25 MHz clock, so each half period is 20 ns.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hung handshake would stall the run, so a cycle ceiling cuts it short.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end

  // Read answers are registered, so the check waits for the edge after the request.
  task automatic msr_rd(input logic [3:0] idx, output logic [63:0] v, output logic flt);
    @(posedge clock);
    req <= '{1'b1, 1'b0, idx, 64'h0};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk({63'h0, rvalid}, 64'h1);
    v = rdata;
    flt = fault;
  endtask

  task automatic msr_wr(input logic [3:0] idx, input logic [63:0] v, output logic flt);
    @(posedge clock);
    req <= '{1'b0, 1'b1, idx, v};
    @(posedge clock);
    req.wr <= 1'b0;
    #1;
    flt = fault;
  endtask

  task automatic send(input mcelb_event_s e);
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev.valid <= 1'b0;
  endtask

  // After reset every mapped register reads zero and unmapped places fault.
  task automatic t_reset_map();
    for (int i = 0; i < 9; i++) begin
      msr_rd(4'(i), d, f);
      chk(d, 64'h0);
      chk({63'h0, f}, 64'h0);
    end
    msr_wr(4'h9, 64'hffff_ffff_ffff_ffff, f);
    chk({63'h0, f}, 64'h1);
    msr_rd(4'hf, d, f);
    chk({63'h0, f}, 64'h1);
    chk(d, 64'h0);
    msr_rd(4'h8, d, f);
    chk(d, 64'h0);
  endtask

  // Only control bit 1 is kept, and bit 37 of a status word never holds a written one.
  task automatic t_ctrl_rsvd();
    msr_wr(4'h8, 64'hffff_ffff_ffff_ffff, f);
    chk({63'h0, ext_en}, 64'h1);
    msr_rd(4'h8, d, f);
    chk(d, 64'h2);
    msr_wr(4'h8, 64'h0, f);
    chk({63'h0, ext_en}, 64'h0);
    msr_wr(4'h6, 64'hffff_ffff_ffff_ffff, f);
    msr_rd(4'h6, d, f);
    chk(d, 64'hffff_ffdf_ffff_ffff);
    msr_wr(4'h6, 64'h0, f);
  endtask

  // Every kind with extended logging off: codes land, device fields stay as software left them except misc 13:9 for write parity kinds.
  task automatic t_kinds_off();
    logic [15:0] codes [8];
    logic [63:0] pat;
    logic [63:0] exp;
    logic [4:0] par;
    codes = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040};
    pat = 64'h5a5a_c3c3_9696_a5a5;
    for (int k = 0; k < 8; k++) begin
      par = 5'h11 + 5'(k);
      msr_wr(4'(2 * (k % 4)), 64'h0, f);
      msr_wr(4'(2 * (k % 4) + 1), pat, f);
      send('{1'b1, 2'(k % 4), 3'(k), 4'ha ^ 4'(k), mcelb_kind_e'(k), 5'h15, 16'hbeef,
        5'h0b, 3'h5, par});
      msr_rd(4'(2 * (k % 4)), d, f);
      chk(d, {32'h0, codes[k], 8'h00, 1'b1, 3'(k), 4'ha ^ 4'(k)});
      exp = (k == 2 || k == 3) ? {pat[63:14], par, pat[8:0]} : pat;
      msr_rd(4'(2 * (k % 4) + 1), d, f);
      chk(d, exp);
    end
  endtask

  // First and second corrected reads fill both device records; a third changes only the class code.
  task automatic t_two_devices();
    logic [63:0] m2;
    msr_wr(4'h2, 64'h0, f);
    msr_wr(4'h3, 64'h0, f);
    msr_wr(4'h8, 64'h2, f);
    send('{1'b1, 2'h1, 3'h2, 4'h5, MCELB_K_READ_CORR, 5'h03, 16'h00f0, 5'h02, 3'h1, 5'h1f});
    msr_rd(4'h2, d, f);
    chk(d, {27'h0, 5'h03, 16'h0, 8'h00, 1'b1, 3'h2, 4'h5});
    msr_rd(4'h3, d, f);
    chk(d, {2'b01, 6'h01, 5'h0, 5'h02, 16'h0, 16'h00f0, 14'h0});
    send('{1'b1, 2'h1, 3'h3, 4'h6, MCELB_K_READ_CORR, 5'h11, 16'ha5c3, 5'h1d, 3'h6, 5'h1f});
    m2 = {2'b11, 3'h6, 3'h1, 5'h1d, 5'h02, 16'ha5c3, 16'h00f0, 5'h11, 9'h0};
    msr_rd(4'h3, d, f);
    chk({63'h0, d[62]}, 64'h1);
    chk(d, m2);
    msr_rd(4'h2, d, f);
    chk(d, {27'h0, 5'h03, 16'h0, 8'h00, 1'b1, 3'h3, 4'h6});
    send('{1'b1, 2'h1, 3'h1, 4'h1, MCELB_K_READ_CORR, 5'h09, 16'hffff, 5'h1f, 3'h7, 5'h1f});
    msr_rd(4'h2, d, f);
    chk(d, {27'h0, 5'h03, 16'h0, 8'h00, 1'b1, 3'h1, 4'h1});
    msr_rd(4'h3, d, f);
    chk(d, m2);
  endtask

  // With extended logging on, a write parity report leaves the parity detail field alone.
  task automatic t_parity_ext_on();
    msr_wr(4'h5, 64'h0, f);
    send('{1'b1, 2'h2, 3'h4, 4'h2, MCELB_K_WB_DATA_PAR, 5'h07, 16'h1234, 5'h04, 3'h2, 5'h1f});
    msr_rd(4'h4, d, f);
    chk({32'h0, d[31:0]}, {32'h0, 16'h0002, 8'h00, 1'b1, 3'h4, 4'h2});
    msr_rd(4'h5, d, f);
    chk({59'h0, d[13:9]}, 64'h0);
    msr_wr(4'h8, 64'h0, f);
    chk({63'h0, ext_en}, 64'h0);
  endtask

  initial begin
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    reset_n = 1'b0;
    ev = '0;
    req = '0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_reset_map();
    t_ctrl_rsvd();
    t_kinds_off();
    t_two_devices();
    t_parity_ext_on();
    results();
  end
endmodule
